/* File: pgt_timer.sv */
// Paired 16/32-bit general purpose timer with holding register and converter trigger.
//
// Design decision made here: the plain strobed port.
`timescale 1ns/10ps
`include "pgt_map.svh"

// Notes on behaviour
// - Paired mode: low count is the low word, high count the high word.
// - Paired mode ignores the high control register, except that turning its timer off clears the low prescaler.
// - Paired mode uses low clock and gate, reports on flag and enable bit 7.
// - Unpaired timers run independently as timer or synchronous counter; no async counting.
// - Low prescaler output is resynchronised one cycle; high prescaler output is not.
// - Paired timer counts each prescaled low tick up to the 32-bit period, then restarts at zero.
// - Reading the low count copies the high count into the holding register.
// - In paired mode, writing the low count loads the held value into the high count.
// - Paired counter mode advances on each prescaled external rising edge up to the period.
// - With idle stop set, counting halts during idle and resumes afterwards.
// - Gate mode with internal clock counts cycles only while the gate pin is high.
// - Paired mode takes gating from the low timer only.
// - Gate falling edge stops accumulation and leaves the count untouched.
// - A 32-bit period match pulses the converter trigger from the high timer.
// - Prescale field bits 5:4 divides by 1, 8, 64 or 256.
// - Paired mode uses only the low prescaler.
// - Count writes, clearing timer on, and reset clear the prescaler.
// - Low prescaler is not cleared while the low timer is off.
// - Control writes leave both counts unchanged.
// - Sleep stops all counting.
// - Period match or gate falling edge sets a sticky flag until software clears it.
module pgt_timer
  import pgt_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  input  wire logic         sys_clk_i,
  input  wire logic         rst_i,
  input  wire pgt_bus_req_t bus_req_i,
  output logic [15:0]       bus_rdata_o,
  input  wire logic         ext_clk_gate_low_i,
  input  wire logic         ext_clk_high_i,
  input  wire logic         cpu_idle_i,
  input  wire logic         cpu_sleep_i,
  output logic              adc_trigger_o,
  output logic              irq_o
);

  // The register port decodes all sixteen address bits, so narrower buses are refused.
  // The offsets in the map are sixteen bits wide as well, so only this width can match them.
  if (ADDR_W != 16) begin : g_addr_check
    $error("pgt_timer supports only a 16-bit register address");
  end

  pgt_state_t s_q;
  pgt_state_t s_d;

  // Prescaler terminal count for a prescale field value.
  function automatic logic [7:0] pre_term(input logic [1:0] sel);
    logic [7:0] t;
    t = `PGT_PRE_TERM_1;
    case (sel)
      2'h0: t = `PGT_PRE_TERM_1;
      2'h1: t = `PGT_PRE_TERM_8;
      2'h2: t = `PGT_PRE_TERM_64;
      2'h3: t = `PGT_PRE_TERM_256;
      default: t = `PGT_PRE_TERM_1;
    endcase
    return t;
  endfunction

  // Decoded bus accesses.
  logic wr_low_cnt;
  logic wr_hold;
  logic wr_high_cnt;
  logic wr_low_per;
  logic wr_high_per;
  logic wr_low_ctl;
  logic wr_high_ctl;
  logic wr_flags;
  logic wr_enables;
  logic rd_low_cnt;

  // Per-timer working terms.
  logic       pair;
  logic       freeze_lo;
  logic       freeze_hi;
  logic       ev_lo;
  logic       ev_hi;
  logic       run_lo;
  logic       run_hi;
  logic       raw_tick_lo;
  logic       raw_tick_hi;
  logic       tick_lo;
  logic       gate_fall_lo;
  logic       gate_fall_hi;
  logic       clr_pre_lo;
  logic       clr_pre_hi;
  // Flag sets, masked control words and the joined 32-bit views.
  logic [15:0] set_flags;
  logic [15:0] ctl_lo_new;
  logic [15:0] ctl_hi_new;
  logic [31:0] cnt32;
  logic [31:0] per32;

  // Address decode; strobes never come together, so one access per cycle.
  always_comb begin
    wr_low_cnt  = bus_req_i.wr && (bus_req_i.addr == `PGT_LOW_COUNT_OFS);
    wr_hold     = bus_req_i.wr && (bus_req_i.addr == `PGT_HOLD_OFS);
    wr_high_cnt = bus_req_i.wr && (bus_req_i.addr == `PGT_HIGH_COUNT_OFS);
    wr_low_per  = bus_req_i.wr && (bus_req_i.addr == `PGT_LOW_PERIOD_OFS);
    wr_high_per = bus_req_i.wr && (bus_req_i.addr == `PGT_HIGH_PERIOD_OFS);
    wr_low_ctl  = bus_req_i.wr && (bus_req_i.addr == `PGT_LOW_CONTROL_OFS);
    wr_high_ctl = bus_req_i.wr && (bus_req_i.addr == `PGT_HIGH_CONTROL_OFS);
    wr_flags    = bus_req_i.wr && (bus_req_i.addr == `PGT_IRQ_FLAG_OFS);
    wr_enables  = bus_req_i.wr && (bus_req_i.addr == `PGT_IRQ_ENABLE_OFS);
    rd_low_cnt  = bus_req_i.rd && (bus_req_i.addr == `PGT_LOW_COUNT_OFS);
  end

  // Next state of the whole block.
  always_comb begin
    s_d          = s_q;
    s_d.adc_trig = 1'b0;
    s_d.rdata    = 16'h0000;
    set_flags    = 16'h0000;

    pair = s_q.low_ctl.pair_select;

    // A freeze also stops the prescaler, so a divided count resumes where it left off.
    // Sleep freezes all.
    freeze_lo = cpu_sleep_i || (cpu_idle_i && s_q.low_ctl.idle_stop);
    freeze_hi = cpu_sleep_i || (cpu_idle_i && s_q.high_ctl.idle_stop);

    // Count events of the low timer: external rising edge, gated cycle or every cycle.
    // External edge counting.
    if (s_q.low_ctl.clock_source_select) begin
      ev_lo = ext_clk_gate_low_i && !s_q.pin_lo_prev;
    end else if (s_q.low_ctl.gate_accumulate_enable) begin
      ev_lo = ext_clk_gate_low_i;
    end else begin
      ev_lo = 1'b1;
    end

    // The high timer keeps its own source only when unpaired.
    // Independent 16-bit timer.
    if (s_q.high_ctl.clock_source_select) begin
      ev_hi = ext_clk_high_i && !s_q.pin_hi_prev;
    end else if (s_q.high_ctl.gate_accumulate_enable) begin
      ev_hi = ext_clk_high_i;
    end else begin
      ev_hi = 1'b1;
    end

    gate_fall_lo = s_q.low_ctl.timer_on && !s_q.low_ctl.clock_source_select &&
                   s_q.low_ctl.gate_accumulate_enable &&
                   s_q.pin_lo_prev && !ext_clk_gate_low_i;
    gate_fall_hi = !pair && s_q.high_ctl.timer_on &&
                   !s_q.high_ctl.clock_source_select &&
                   s_q.high_ctl.gate_accumulate_enable &&
                   s_q.pin_hi_prev && !ext_clk_high_i;

    // A timer runs when it is on, not frozen, unpaired if it is the high one, and has an event in this cycle.
    run_lo = s_q.low_ctl.timer_on && !freeze_lo && ev_lo;
    run_hi = !pair && s_q.high_ctl.timer_on && !freeze_hi && ev_hi;

    raw_tick_lo = 1'b0;
    if (run_lo) begin
      if (s_q.pre_lo == pre_term(s_q.low_ctl.prescale_select)) begin
        s_d.pre_lo  = 8'h00;
        raw_tick_lo = 1'b1;
      end else begin
        s_d.pre_lo = s_q.pre_lo + 8'h01;
      end
    end

    raw_tick_hi = 1'b0;
    if (run_hi) begin
      if (s_q.pre_hi == pre_term(s_q.high_ctl.prescale_select)) begin
        s_d.pre_hi  = 8'h00;
        raw_tick_hi = 1'b1;
      end else begin
        s_d.pre_hi = s_q.pre_hi + 8'h01;
      end
    end

    // Low tick resynchronised.
    // The extra flop costs one cycle of latency on every low tick; the high path has none.
    // Frozen low tick held.
    // A tick caught in the flop waits out sleep or idle, so no count lands while frozen
    // and none is lost when the freeze ends.
    if (freeze_lo) begin
      s_d.tick_lo_sync = s_q.tick_lo_sync;
    end else begin
      s_d.tick_lo_sync = raw_tick_lo;
    end
    tick_lo = s_q.tick_lo_sync && s_q.low_ctl.timer_on && !freeze_lo;

    // The joined views feed both the period compare and the 32-bit add.
    // High word, low word.
    cnt32 = {s_q.high_cnt, s_q.low_cnt};
    per32 = {s_q.high_per, s_q.low_per};

    if (pair) begin
      if (tick_lo) begin
        if (cnt32 == per32) begin
          s_d.low_cnt  = `PGT_COUNT_RST;
          s_d.high_cnt = `PGT_COUNT_RST;
          s_d.adc_trig = 1'b1;
          set_flags[`PGT_PAIR_IRQ_BIT] = 1'b1;
        end else begin
          // One wide add carries into the high word in the same cycle as the low wrap.
          {s_d.high_cnt, s_d.low_cnt} = cnt32 + 32'h0000_0001;
        end
      end
      if (gate_fall_lo) begin
        set_flags[`PGT_PAIR_IRQ_BIT] = 1'b1;
      end
    end else begin
      // Unpaired, the low timer reports on its own flag bit and never on the pair bit.
      // Low timer on its own.
      if (tick_lo) begin
        if (s_q.low_cnt == s_q.low_per) begin
          s_d.low_cnt = `PGT_COUNT_RST;
          set_flags[`PGT_LOW_IRQ_BIT] = 1'b1;
        end else begin
          s_d.low_cnt = s_q.low_cnt + 16'h0001;
        end
      end
      if (gate_fall_lo) begin
        set_flags[`PGT_LOW_IRQ_BIT] = 1'b1;
      end
      if (raw_tick_hi) begin
        if (s_q.high_cnt == s_q.high_per) begin
          s_d.high_cnt = `PGT_COUNT_RST;
          s_d.adc_trig = 1'b1;
          set_flags[`PGT_PAIR_IRQ_BIT] = 1'b1;
        end else begin
          s_d.high_cnt = s_q.high_cnt + 16'h0001;
        end
      end
      if (gate_fall_hi) begin
        set_flags[`PGT_PAIR_IRQ_BIT] = 1'b1;
      end
    end

    // Edge detectors see the pins as they stood in the previous cycle.
    s_d.pin_lo_prev = ext_clk_gate_low_i;
    s_d.pin_hi_prev = ext_clk_high_i;

    // Software writes to the counts win over a tick in the same cycle.
    if (wr_low_cnt) begin
      s_d.low_cnt = bus_req_i.wdata;
      if (pair) begin
        s_d.high_cnt = s_q.hold;
      end
    end
    if (wr_high_cnt) begin
      s_d.high_cnt = bus_req_i.wdata;
    end
    if (wr_hold) begin
      s_d.hold = bus_req_i.wdata;
    end
    // A hold write and a low read never meet, since the strobes never come together.
    // Capture high word.
    if (rd_low_cnt) begin
      s_d.hold = s_q.high_cnt;
    end
    if (wr_low_per) begin
      s_d.low_per = bus_req_i.wdata;
    end
    if (wr_high_per) begin
      s_d.high_per = bus_req_i.wdata;
    end

    // Reserved bits are dropped here, so reads show only what is implemented.
    // Control writes only.
    ctl_lo_new = bus_req_i.wdata & `PGT_LOW_CTL_MASK;
    ctl_hi_new = bus_req_i.wdata & `PGT_HIGH_CTL_MASK;
    if (wr_low_ctl) begin
      s_d.low_ctl = pgt_ctl_t'(ctl_lo_new);
    end
    if (wr_high_ctl) begin
      s_d.high_ctl = pgt_ctl_t'(ctl_hi_new);
    end

    clr_pre_lo = wr_low_cnt || wr_high_cnt ||
                 (wr_low_ctl && s_q.low_ctl.timer_on &&
                  !ctl_lo_new[`PGT_TIMER_ON_BIT]) ||
                 (wr_high_ctl && s_q.high_ctl.timer_on &&
                  !ctl_hi_new[`PGT_TIMER_ON_BIT]);
    // One clear serves both prescalers; the halted low prescaler is the one exception.
    clr_pre_hi = clr_pre_lo;
    if (clr_pre_lo && s_q.low_ctl.timer_on) begin
      s_d.pre_lo       = 8'h00;
      s_d.tick_lo_sync = 1'b0;
    end
    if (clr_pre_hi) begin
      s_d.pre_hi = 8'h00;
    end

    // Software clears by writing zero; a hardware set in the same cycle still lands.
    // Sticky flags, set wins.
    if (wr_flags) begin
      s_d.flags = (bus_req_i.wdata & `PGT_IRQ_MASK) | set_flags;
    end else begin
      s_d.flags = s_q.flags | set_flags;
    end
    if (wr_enables) begin
      s_d.enables = bus_req_i.wdata & `PGT_IRQ_MASK;
    end

    // Read data stands only in the cycle after the read strobe.
    if (bus_req_i.rd) begin
      case (bus_req_i.addr)
        `PGT_LOW_COUNT_OFS:    s_d.rdata = s_q.low_cnt;
        `PGT_HOLD_OFS:         s_d.rdata = s_q.hold;
        `PGT_HIGH_COUNT_OFS:   s_d.rdata = s_q.high_cnt;
        `PGT_LOW_PERIOD_OFS:   s_d.rdata = s_q.low_per;
        `PGT_HIGH_PERIOD_OFS:  s_d.rdata = s_q.high_per;
        `PGT_LOW_CONTROL_OFS:  s_d.rdata = s_q.low_ctl;
        `PGT_HIGH_CONTROL_OFS: s_d.rdata = s_q.high_ctl;
        `PGT_IRQ_FLAG_OFS:     s_d.rdata = s_q.flags;
        `PGT_IRQ_ENABLE_OFS:   s_d.rdata = s_q.enables;
        default:               s_d.rdata = 16'h0000;
      endcase
    end
  end

  // State register; all fields take constants under reset.
  // Reset is synchronous, so every flop of the block acts on the one clock edge.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      s_q.low_cnt      <= `PGT_COUNT_RST;
      s_q.high_cnt     <= `PGT_COUNT_RST;
      s_q.hold         <= `PGT_COUNT_RST;
      s_q.low_per      <= `PGT_PERIOD_RST;
      s_q.high_per     <= `PGT_PERIOD_RST;
      s_q.low_ctl      <= pgt_ctl_t'(`PGT_CTL_RST);
      s_q.high_ctl     <= pgt_ctl_t'(`PGT_CTL_RST);
      s_q.pre_lo       <= 8'h00;
      s_q.pre_hi       <= 8'h00;
      s_q.tick_lo_sync <= 1'b0;
      s_q.pin_lo_prev  <= 1'b0;
      s_q.pin_hi_prev  <= 1'b0;
      s_q.flags        <= 16'h0000;
      s_q.enables      <= 16'h0000;
      s_q.rdata        <= 16'h0000;
      s_q.adc_trig     <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs come straight from the state; the interrupt is a level of flag and enable.
  // The request stays high for as long as software leaves both flag and enable set.
  // Enable gates the flag.
  assign bus_rdata_o   = s_q.rdata;
  assign adc_trigger_o = s_q.adc_trig;
  assign irq_o         = |(s_q.flags & s_q.enables);

endmodule // pgt_timer

/* File: pgt_map.svh */
// Register offsets, field positions, reset values and masks of the paired timer.
`ifndef PGT_MAP_SVH
`define PGT_MAP_SVH

// Register offsets on the plain register port.
`define PGT_LOW_COUNT_OFS     16'h0106
`define PGT_HOLD_OFS          16'h0108
`define PGT_HIGH_COUNT_OFS    16'h010a
`define PGT_LOW_PERIOD_OFS    16'h010c
`define PGT_HIGH_PERIOD_OFS   16'h010e
`define PGT_LOW_CONTROL_OFS   16'h0110
`define PGT_HIGH_CONTROL_OFS  16'h0112
`define PGT_IRQ_FLAG_OFS      16'h0084
`define PGT_IRQ_ENABLE_OFS    16'h0094

// Control field positions.
`define PGT_TIMER_ON_BIT      15
`define PGT_IDLE_STOP_BIT     13
`define PGT_GATE_BIT          6
`define PGT_PRESCALE_HI_BIT   5
`define PGT_PRESCALE_LO_BIT   4
`define PGT_PAIR_BIT          3
`define PGT_CLK_SRC_BIT       1

// Interrupt flag and enable positions.
`define PGT_LOW_IRQ_BIT       6
`define PGT_PAIR_IRQ_BIT      7

// Writable bits of each control register and of the flag and enable registers; the rest read as zero.
`define PGT_LOW_CTL_MASK      16'ha07a
`define PGT_HIGH_CTL_MASK     16'ha072
`define PGT_IRQ_MASK          16'h00c0

// Reset values.
`define PGT_COUNT_RST         16'h0000
`define PGT_PERIOD_RST        16'hffff
`define PGT_CTL_RST           16'h0000

// Prescaler terminal counts for divide by 1, 8, 64 and 256.
`define PGT_PRE_TERM_1        8'h00
`define PGT_PRE_TERM_8        8'h07
`define PGT_PRE_TERM_64       8'h3f
`define PGT_PRE_TERM_256      8'hff

`endif

/* File: pgt_pkg.sv */
// Types shared by the paired timer and its surroundings.
package pgt_pkg;

  // One access on the plain register port.
  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } pgt_bus_req_t;

  // Control register layout, bit 15 first.
  typedef struct packed {
    logic       timer_on;
    logic       rsv14;
    logic       idle_stop;
    logic [5:0] rsv12_7;
    logic       gate_accumulate_enable;
    logic [1:0] prescale_select;
    logic       pair_select;
    logic       rsv2;
    logic       clock_source_select;
    logic       rsv0;
  } pgt_ctl_t;

  // Whole state of the timer pair.
  typedef struct packed {
    logic [15:0] low_cnt;
    logic [15:0] high_cnt;
    logic [15:0] hold;
    logic [15:0] low_per;
    logic [15:0] high_per;
    pgt_ctl_t    low_ctl;
    pgt_ctl_t    high_ctl;
    logic [7:0]  pre_lo;
    logic [7:0]  pre_hi;
    logic        tick_lo_sync;
    logic        pin_lo_prev;
    logic        pin_hi_prev;
    logic [15:0] flags;
    logic [15:0] enables;
    logic [15:0] rdata;
    logic        adc_trig;
  } pgt_state_t;

endpackage

/* File: pgt_ext_model.sv */
// Model of the pin source that stands outside the paired timer.
`timescale 1ns/10ps
module pgt_ext_model (
  input  wire logic sys_clk_i,
  output logic      pin_low_o,
  output logic      pin_high_o
);
  initial begin
    pin_low_o  = 1'b0;
    pin_high_o = 1'b0;
  end
  // high pin noise.
  // The high pin toggles all the time, so that a paired timer that listened to it would slip.
  always @(posedge sys_clk_i) begin
    pin_high_o <= ~pin_high_o;
  end
  // pin pulses.
  // Sends n pulses, hi cycles high and lo cycles low, changed only after a clock edge.
  task automatic pulse(input int n, input int hi, input int lo);
    repeat (n) begin
      @(posedge sys_clk_i);
      pin_low_o <= 1'b1;
      repeat (hi) @(posedge sys_clk_i);
      pin_low_o <= 1'b0;
      repeat (lo - 1) @(posedge sys_clk_i);
    end
  endtask
endmodule // pgt_ext_model

/* File: pgt_timer_checker.sv */
// Port-level assertions for the paired timer.
`timescale 1ns/10ps
`include "pgt_map.svh"
module pgt_timer_checker
  import pgt_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  input wire logic         sys_clk_i,
  input wire logic         rst_i,
  input wire pgt_bus_req_t bus_req_i,
  input wire logic [15:0]  bus_rdata_o,
  input wire logic         ext_clk_gate_low_i,
  input wire logic         ext_clk_high_i,
  input wire logic         cpu_idle_i,
  input wire logic         cpu_sleep_i,
  input wire logic         adc_trigger_o,
  input wire logic         irq_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  logic [15:0] a;
  logic        rd_lo, rd_hi, rd_hd, wr_lo, wr_hd, wr_ctl, wr_irq;
  logic        pair_q, idle_q, en7_q;
  // Access decodes for the sequences below.
  assign a      = bus_req_i.addr;
  assign rd_lo  = bus_req_i.rd && a == `PGT_LOW_COUNT_OFS;
  assign rd_hi  = bus_req_i.rd && a == `PGT_HIGH_COUNT_OFS;
  assign rd_hd  = bus_req_i.rd && a == `PGT_HOLD_OFS;
  assign wr_lo  = bus_req_i.wr && a == `PGT_LOW_COUNT_OFS;
  assign wr_hd  = bus_req_i.wr && a == `PGT_HOLD_OFS;
  assign wr_ctl = bus_req_i.wr && (a == `PGT_LOW_CONTROL_OFS || a == `PGT_HIGH_CONTROL_OFS);
  assign wr_irq = bus_req_i.wr && (a == `PGT_IRQ_FLAG_OFS || a == `PGT_IRQ_ENABLE_OFS);
  // Shadow of the few control and enable bits that decide whether a check applies.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pair_q <= 1'b0;
      idle_q <= 1'b0;
      en7_q  <= 1'b0;
    end else begin
      if (bus_req_i.wr && a == `PGT_LOW_CONTROL_OFS) begin
        pair_q <= bus_req_i.wdata[3];
        idle_q <= bus_req_i.wdata[13];
      end
      if (bus_req_i.wr && a == `PGT_IRQ_ENABLE_OFS) begin
        en7_q <= bus_req_i.wdata[7];
      end
    end
  end
  // Sleep one cycle ahead covers the resync flop of the low timer.
  sequence s_split_read;
    cpu_sleep_i ##1 rd_hi && cpu_sleep_i ##1 rd_lo && cpu_sleep_i ##1 rd_hd;
  endsequence
  sequence s_split_write;
    wr_hd && cpu_sleep_i ##1 wr_lo && pair_q && cpu_sleep_i ##1 rd_hi && cpu_sleep_i;
  endsequence
  sequence s_ctl_between;
    cpu_sleep_i ##1 rd_lo && cpu_sleep_i ##1 wr_ctl && cpu_sleep_i ##1 rd_lo;
  endsequence
  sequence s_idle_reads;
    cpu_idle_i && idle_q ##1 rd_lo && cpu_idle_i && idle_q
      ##1 cpu_idle_i && !bus_req_i.wr ##1 rd_lo && cpu_idle_i;
  endsequence
  a_rdata_slot_only:
    assert property (!$past(bus_req_i.rd) |-> bus_rdata_o == 16'h0000)
    else $error("read data outside its slot");
  a_split_read:
    assert property (s_split_read |=> bus_rdata_o == $past(bus_rdata_o, 2))
    else $error("holding word differs from high count");
  a_split_write:
    assert property (s_split_write |=> bus_rdata_o == $past(bus_req_i.wdata, 3))
    else $error("high count not loaded from holding word");
  a_ctl_keeps_count:
    assert property (s_ctl_between |=> bus_rdata_o == $past(bus_rdata_o, 2))
    else $error("control write moved the count");
  a_idle_freeze:
    assert property (s_idle_reads |=> bus_rdata_o == $past(bus_rdata_o, 2))
    else $error("count moved in idle with stop set");
  a_sleep_no_trig:
    assert property (cpu_sleep_i [*4] |-> !adc_trigger_o)
    else $error("trigger during sleep");
  a_trig_sets_irq:
    assert property (adc_trigger_o && en7_q |-> irq_o)
    else $error("match without enabled request");
  a_irq_sticky:
    assert property (irq_o && !wr_irq |=> irq_o)
    else $error("request dropped without software");
endmodule // pgt_timer_checker

bind pgt_timer pgt_timer_checker #(.ADDR_W(ADDR_W)) i_pgt_timer_checker (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .bus_req_i(bus_req_i), .bus_rdata_o(bus_rdata_o),
  .ext_clk_gate_low_i(ext_clk_gate_low_i), .ext_clk_high_i(ext_clk_high_i),
  .cpu_idle_i(cpu_idle_i), .cpu_sleep_i(cpu_sleep_i), .adc_trigger_o(adc_trigger_o),
  .irq_o(irq_o)
);

/* File: paired_gp_timer_32bit_test.sv */
// Register-level test of the paired timer.
`timescale 1ns/10ps
`include "pgt_map.svh"
module paired_gp_timer_32bit_test;
  import pgt_pkg::*;
  logic         sys_clk_i, rst_i, pin_lo, pin_hi, idle, sleep, trig, irq;
  pgt_bus_req_t bus_req_i;
  logic [15:0]  bus_rdata_o, rv, v1;
  int           err_count, checks_done, n;
  localparam logic [15:0] OFS [8] = '{`PGT_LOW_COUNT_OFS, `PGT_HOLD_OFS, `PGT_HIGH_COUNT_OFS,
    `PGT_LOW_PERIOD_OFS, `PGT_HIGH_PERIOD_OFS, `PGT_LOW_CONTROL_OFS, `PGT_HIGH_CONTROL_OFS,
    16'h0200};
  localparam logic [15:0] RSTV [8] = '{16'h0, 16'h0, 16'h0, 16'hffff, 16'hffff, 16'h0, 16'h0,
    16'h0};
  localparam int DIV [4] = '{1, 8, 64, 256};

  pgt_timer i_pgt_timer (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .bus_req_i(bus_req_i), .bus_rdata_o(bus_rdata_o),
    .ext_clk_gate_low_i(pin_lo), .ext_clk_high_i(pin_hi), .cpu_idle_i(idle),
    .cpu_sleep_i(sleep), .adc_trigger_o(trig), .irq_o(irq)
  );
  pgt_ext_model i_pgt_ext_model (.sys_clk_i(sys_clk_i), .pin_low_o(pin_lo), .pin_high_o(pin_hi));

  // One access; it is held until the next call, so back-to-back strobes need no gap.
  task automatic acc(input logic w, input logic [15:0] ad, input logic [15:0] d);
    bus_req_i <= '{addr: ad, wdata: d, wr: w, rd: !w};
    @(posedge sys_clk_i);
    #1;
    rv = bus_rdata_o;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [15:0] ad, input logic [15:0] exp);
    acc(1'b0, ad, 16'h0000);
    chk(rv, exp);
  endtask
  // Counts cycles up to the next trigger pulse, bounded.
  task automatic wait_trig(output int k);
    k = 0;
    do begin
      @(posedge sys_clk_i);
      #1;
      k++;
    end while (trig !== 1'b1 && k < 2000);
    if (k >= 2000) begin
      err_count++;
      wrap_up();
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  // A hang ends the run as a mismatch.
  initial begin
    repeat (100000) @(posedge sys_clk_i);
    err_count++;
    wrap_up();
  end
  initial begin
    rst_i       = 1'b1;
    bus_req_i   = '0;
    idle        = 1'b0;
    sleep       = 1'b1;
    err_count   = 0;
    checks_done = 0;
    repeat (10) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    @(posedge sys_clk_i);
    #1;
    // Reset values, an unmapped read and the writable control bits.
    foreach (OFS[i]) rdc(OFS[i], RSTV[i]);
    acc(1'b1, `PGT_LOW_CONTROL_OFS, 16'hffff);
    rdc(`PGT_LOW_CONTROL_OFS, `PGT_LOW_CTL_MASK);
    acc(1'b1, `PGT_HIGH_CONTROL_OFS, 16'hffff);
    rdc(`PGT_HIGH_CONTROL_OFS, `PGT_HIGH_CTL_MASK);
    $display("register test done");
    acc(1'b1, `PGT_LOW_CONTROL_OFS, 16'h0008);
    acc(1'b1, `PGT_HOLD_OFS, 16'h1234);
    acc(1'b1, `PGT_LOW_COUNT_OFS, 16'h0042);
    rdc(`PGT_HIGH_COUNT_OFS, 16'h1234);
    acc(1'b0, `PGT_LOW_COUNT_OFS, 16'h0000);
    acc(1'b1, `PGT_HIGH_CONTROL_OFS, 16'h8030);
    rdc(`PGT_LOW_COUNT_OFS, 16'h0042);
    acc(1'b1, `PGT_HOLD_OFS, 16'h0000);
    acc(1'b0, `PGT_HIGH_COUNT_OFS, 16'h0000);
    acc(1'b0, `PGT_LOW_COUNT_OFS, 16'h0000);
    rdc(`PGT_HOLD_OFS, 16'h1234);
    $display("split access test done");
    // period and prescale, high control left running.
    sleep <= 1'b0;
    acc(1'b1, `PGT_HIGH_PERIOD_OFS, 16'h0000);
    acc(1'b1, `PGT_LOW_PERIOD_OFS, 16'h0002);
    acc(1'b1, `PGT_IRQ_ENABLE_OFS, 16'h0080);
    for (int p = 0; p < 4; p++) begin
      acc(1'b1, `PGT_LOW_CONTROL_OFS, 16'h8008 | 16'(p << 4));
      acc(1'b1, `PGT_HOLD_OFS, 16'h0000);
      acc(1'b1, `PGT_LOW_COUNT_OFS, 16'h0000);
      bus_req_i <= '0;
      wait_trig(n);
      wait_trig(n);
      wait_trig(n);
      chk(16'(n), 16'(3 * DIV[p]));
    end
    chk({15'h0000, irq}, 16'h0001);
    acc(1'b1, `PGT_LOW_CONTROL_OFS, 16'h0000);
    rdc(`PGT_IRQ_FLAG_OFS, 16'h0080);
    acc(1'b1, `PGT_IRQ_FLAG_OFS, 16'h0000);
    chk({15'h0000, irq}, 16'h0000);
    $display("period test done");
    acc(1'b1, `PGT_LOW_PERIOD_OFS, 16'hffff);
    acc(1'b1, `PGT_HIGH_PERIOD_OFS, 16'hffff);
    acc(1'b1, `PGT_LOW_CONTROL_OFS, 16'h8048);
    acc(1'b1, `PGT_LOW_COUNT_OFS, 16'h0000);
    bus_req_i <= '0;
    i_pgt_ext_model.pulse(1, 10, 4);
    rdc(`PGT_LOW_COUNT_OFS, 16'h000a);
    rdc(`PGT_IRQ_FLAG_OFS, 16'h0080);
    rdc(`PGT_LOW_COUNT_OFS, 16'h000a);
    $display("gate test done");
    acc(1'b1, `PGT_LOW_CONTROL_OFS, 16'h800a);
    acc(1'b1, `PGT_LOW_COUNT_OFS, 16'h0000);
    bus_req_i <= '0;
    i_pgt_ext_model.pulse(5, 2, 2);
    rdc(`PGT_LOW_COUNT_OFS, 16'h0005);
    $display("counter test done");
    // idle with stop set, then cleared.
    idle <= 1'b1;
    acc(1'b1, `PGT_LOW_CONTROL_OFS, 16'ha008);
    acc(1'b0, `PGT_HOLD_OFS, 16'h0000);
    acc(1'b0, `PGT_LOW_COUNT_OFS, 16'h0000);
    v1 = rv;
    acc(1'b0, `PGT_HOLD_OFS, 16'h0000);
    rdc(`PGT_LOW_COUNT_OFS, v1);
    acc(1'b1, `PGT_LOW_CONTROL_OFS, 16'h8008);
    acc(1'b0, `PGT_HOLD_OFS, 16'h0000);
    acc(1'b0, `PGT_LOW_COUNT_OFS, 16'h0000);
    v1 = rv;
    acc(1'b0, `PGT_HOLD_OFS, 16'h0000);
    acc(1'b0, `PGT_LOW_COUNT_OFS, 16'h0000);
    chk(rv - v1, 16'h0002);
    idle <= 1'b0;
    $display("idle test done");
    // sleep halts a running paired timer.
    sleep <= 1'b1;
    acc(1'b0, `PGT_HOLD_OFS, 16'h0000);
    acc(1'b0, `PGT_LOW_COUNT_OFS, 16'h0000);
    v1 = rv;
    acc(1'b0, `PGT_HOLD_OFS, 16'h0000);
    rdc(`PGT_LOW_COUNT_OFS, v1);
    sleep <= 1'b0;
    $display("sleep test done");
    // unpaired halves: the low word ticks a cycle late, the high word does not.
    acc(1'b1, `PGT_HIGH_CONTROL_OFS, 16'h0000);
    acc(1'b1, `PGT_LOW_CONTROL_OFS, 16'h8000);
    acc(1'b1, `PGT_HIGH_COUNT_OFS, 16'h0077);
    acc(1'b1, `PGT_HOLD_OFS, 16'h1234);
    acc(1'b1, `PGT_LOW_COUNT_OFS, 16'h0000);
    rdc(`PGT_HIGH_COUNT_OFS, 16'h0077);
    rdc(`PGT_LOW_COUNT_OFS, 16'h0000);
    rdc(`PGT_LOW_COUNT_OFS, 16'h0001);
    acc(1'b1, `PGT_HIGH_PERIOD_OFS, 16'h0002);
    acc(1'b1, `PGT_HIGH_CONTROL_OFS, 16'h8000);
    acc(1'b1, `PGT_HIGH_COUNT_OFS, 16'h0000);
    bus_req_i <= '0;
    wait_trig(n);
    wait_trig(n);
    chk(16'(n), 16'h0003);
    $display("unpaired test done");
    wrap_up();
  end
endmodule // paired_gp_timer_32bit_test
